// ==== cascade_trigger_sync_bench.sv ====
// Purpose: Self-checking bench for the cascade trigger block.
// Assumes: MS_DIV 20 and US_DIV 4 shorten the time units.
// Notes: Master period is chosen longer than the trigger pulse.
`timescale 1ns/1ns
module cascade_trigger_sync_bench;
  import cts_pkg::*;
  localparam int unsigned MSD = 20;
  localparam int unsigned USD = 4;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        err;
  logic        pready;
  logic        pslverr;
  logic        trig_pin_o;
  logic        trig_pin_oe;
  logic        scan_start_o;
  logic        far_o;
  logic        far_oe;
  wire         line = trig_pin_oe ? trig_pin_o : (far_oe ? far_o : 1'b0);
  int          fails;
  int          compares;
  int          n;

  initial pclk = 1'b0;
  always #2 pclk = ~pclk;

  cts_top #(.MS_DIV(MSD), .US_DIV(USD)) dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trig_pin_i(line), .trig_pin_o(trig_pin_o),
    .trig_pin_oe(trig_pin_oe), .scan_start_o(scan_start_o)
  );
  cts_far_curtain far (.pclk(pclk), .line_i(line), .drv_o(far_o), .drv_oe(far_oe));

  // ---------------------------------
  // Shared tasks
  // ---------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits for the answer however long it takes; the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic od(input logic o, input logic [3:0] s, input logic w, input logic [31:0] d);
    apb(1'b1, OD_SEL_OFS, {23'h0, o, 4'h0, s});
    apb(w, OD_DATA_OFS, d);
  endtask
  task automatic wait_scan(input int lim);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (scan_start_o !== 1'b1 && n < lim);
  endtask
  task automatic final_report;
    $display("counts compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ---------------------------------
  // Scenarios
  // ---------------------------------
  task automatic t_reset;
    apb(1'b0, CASC_HI_OFS, 32'h0);
    chk("casc_hi reset", 32'h0, rd);
    apb(1'b0, PIN_OFS, 32'h0);
    chk("pin reset", 32'h0, rd);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("status reset", 32'h0, rd);
    $display("done reset");
  endtask
  task automatic t_regs;
    apb(1'b1, CASC_HI_OFS, 32'h010100c8);
    apb(1'b0, CASC_HI_OFS, 32'h0);
    chk("casc_hi", 32'h010100c8, rd);
    apb(1'b1, PIN_OFS, 32'h00000003);
    apb(1'b0, PIN_OFS, 32'h0);
    chk("pin", 32'h00000003, rd);
    od(1'b0, SUB_CYCLE, 1'b0, 32'h0);
    chk("od cycle", 32'h000000c8, rd);
    od(1'b0, SUB_DELAY, 1'b0, 32'h0);
    chk("od delay", 32'h0, rd);
    od(1'b1, SUB_OUTFN, 1'b0, 32'h0);
    chk("od outfn", 32'h00000003, rd);
    od(1'b0, 4'h4, 1'b1, 32'h5);
    chk("od bad sub", 32'h1, {31'h0, err});
    apb(1'b1, STAT_OFS, 32'hffffffff);
    chk("status write", 32'h1, {31'h0, err});
    apb(1'b1, 8'h18, 32'h1);
    chk("unmapped", 32'h1, {31'h0, err});
    apb(1'b1, CASC_LO_OFS, 32'hffffffff);
    apb(1'b0, CASC_LO_OFS, 32'h0);
    chk("casc_lo", 32'h0, rd);
    $display("done regs");
  endtask
  task automatic t_master;
    int e0;
    wait_scan(6000);
    chk("master oe", 32'h1, {31'h0, trig_pin_oe});
    e0 = far.edges;
    @(posedge pclk);
    chk("pin active", 32'h1, {31'h0, trig_pin_o});
    wait_scan(6000);
    chk("period a", 200 * MSD - 1, n);
    wait_scan(6000);
    chk("period b", 200 * MSD, n);
    chk("pulses", 32'h2, far.edges - e0);
    $display("done master");
  endtask
  task automatic t_disable;
    apb(1'b1, CASC_HI_OFS, 32'h000100c8);
    repeat (4) @(posedge pclk);
    chk("oe off", 32'h0, {31'h0, trig_pin_oe});
    wait_scan(5000);
    chk("no scan", 5000, n);
    $display("done disable");
  endtask
  task automatic t_slave;
    int cnt;
    od(1'b0, SUB_EN, 1'b1, 32'h1);
    od(1'b0, SUB_ROLE, 1'b1, 32'h0);
    od(1'b0, SUB_DELAY, 1'b1, 32'd10 + 32'd20);
    od(1'b1, SUB_DIR, 1'b1, 32'h1);
    od(1'b1, SUB_SW, 1'b1, 32'h0);
    od(1'b1, SUB_INFN, 1'b1, 32'h1);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("slave valid", 32'h2, rd & 32'h3f);
    apb(1'b0, CASC_HI_OFS, 32'h0);
    chk("slave casc_hi", 32'h0100001e, rd);
    wait_scan(300);
    chk("idle slave", 300, n);
    fork
      far.pulse(20);
      wait_scan(400);
    join
    chk("delay", 32'h1, {31'h0, n >= 30 * USD - 1 && n <= 30 * USD + 8});
    cnt = 0;
    fork
      begin
        far.pulse(4);
        repeat (10) @(posedge pclk);
        far.pulse(4);
      end
      repeat (600) begin
        @(posedge pclk);
        if (scan_start_o === 1'b1) cnt++;
      end
    join
    chk("one scan", 32'h1, cnt);
    od(1'b0, SUB_DELAY, 1'b1, 32'h0);
    fork
      far.pulse(4);
      wait_scan(50);
    join
    chk("zero delay", 32'd4, n);
    $display("done slave");
  endtask

  initial begin
    fails = 0;
    compares = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_regs;
    t_master;
    t_disable;
    t_slave;
    final_report;
  end

  initial begin
    repeat (40000) @(posedge pclk);
    fails++;
    $display("mismatch watchdog expected done seen hang");
    final_report;
  end
endmodule

// ==== cts_far_curtain.sv ====
// Purpose: Model of another curtain on the shared trigger line.
// Assumes: Line pulled down when nobody drives it.
// Notes: Counts trigger pulses, can act as cascade master.
`timescale 1ns/1ns
module cts_far_curtain (
  // Clock
  input wire logic pclk,
  // Shared trigger line
  input wire logic line_i,
  output logic     drv_o,
  output logic     drv_oe
);
  int   edges;
  logic line_q;
  initial begin
    drv_o = 1'b0;
    drv_oe = 1'b0;
    edges = 0;
    line_q = 1'b0;
  end
  // Light switching: a pulse starts with a rising edge
  always @(posedge pclk) begin
    line_q <= line_i;
    if (line_i && !line_q) begin
      edges <= edges + 1;
    end
  end
  // Drives one trigger pulse, then releases the line
  task automatic pulse(input int n);
    @(posedge pclk);
    drv_oe <= 1'b1;
    drv_o <= 1'b1;
    repeat (n) @(posedge pclk);
    drv_o <= 1'b0;
    @(posedge pclk);
    drv_oe <= 1'b0;
  endtask
endmodule

// ==== cts_monitor.sv ====
// Purpose: Port checker for the cascade trigger block.
// Assumes: One pclk domain, reset presetn active low.
// Notes: Bound to every cts_top instance.
`timescale 1ns/1ns
module cts_monitor #(
  parameter int unsigned MS_DIV = 20,
  parameter int unsigned US_DIV = 4
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pin and scan
  input wire logic        trig_pin_i,
  input wire logic        trig_pin_o,
  input wire logic        trig_pin_oe,
  input wire logic        scan_start_o
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ---------------------------------
  // Cycles since the last completed write, with or without pslverr
  // ---------------------------------
  logic [2:0] wr_age;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_age <= 3'h7;
    end else if (psel && penable && pready && pwrite) begin
      wr_age <= 3'h0;
    end else if (wr_age != 3'h7) begin
      wr_age <= wr_age + 3'h1;
    end
  end
  // ---------------------------------
  // Assertions
  // ---------------------------------
  AST_PREADY_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("pready not one wait state");
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_SLVERR_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_PRDATA_ZERO: assert property ((!pready || pwrite || pslverr) |-> prdata == 32'h0)
    else $error("prdata not zero outside a read");
  AST_SCAN_ONE: assert property (scan_start_o |=> !scan_start_o)
    else $error("scan start longer than one cycle");
  AST_MASTER_PIN: assert property (scan_start_o && trig_pin_oe |=> $changed(trig_pin_o))
    else $error("trigger not driven after master scan");
  AST_RESET_QUIET: assert property ($rose(presetn) |-> !trig_pin_oe && !scan_start_o && !pready)
    else $error("outputs active after reset");
  AST_OE_BY_WRITE: assert property ($changed(trig_pin_oe) |-> wr_age < 3'h5)
    else $error("pin enable changed without a write");
endmodule

bind cts_top cts_monitor #(.MS_DIV(MS_DIV), .US_DIV(US_DIV)) mon (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .trig_pin_i(trig_pin_i), .trig_pin_o(trig_pin_o),
  .trig_pin_oe(trig_pin_oe), .scan_start_o(scan_start_o)
);

// ==== cts_pin.sv ====
// Purpose: Multipurpose pin stage: drives the trigger pulse or detects incoming edges.
// Assumes: Pin input synchronous to pclk.
// Notes: Polarity from switching behaviour; light switching means active high.
`timescale 1ns/1ns
module cts_pin
  import cts_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Core side
  cts_pin_if.pin    pif,
  // Pin
  input  wire logic trig_pin_i,
  output logic      trig_pin_o,
  output logic      trig_pin_oe
);
  localparam int PW = $clog2(TRIG_PULSE_CYCLES + 1);

  logic [PW-1:0] pulse_reg;
  logic          level_reg;
  logic          active_in;

  assign active_in = trig_pin_i ^ pif.invert;

  // Output pulse stretcher
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_reg   <= '0;
      trig_pin_o  <= 1'b0;
      trig_pin_oe <= 1'b0;
    end else begin
      if (pif.fire) begin
        pulse_reg <= PW'(TRIG_PULSE_CYCLES - 1);
      end else if (pulse_reg != '0) begin
        pulse_reg <= pulse_reg - PW'(1);
      end
      trig_pin_oe <= pif.drive_en;
      trig_pin_o  <= (pif.fire || pulse_reg != '0) ^ pif.invert;
    end
  end

  // Rising edge of the active level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_reg     <= 1'b0;
      pif.edge_seen <= 1'b0;
    end else begin
      level_reg     <= active_in;
      pif.edge_seen <= active_in && !level_reg && !pif.drive_en;
    end
  end
endmodule

// ==== cts_pin_if.sv ====
// Purpose: Carries trigger requests and detected edges between core and pin stage.
// Assumes: One clock domain.
// Notes: Core drives requests, pin stage reports edges.
`timescale 1ns/1ns
interface cts_pin_if;
  logic fire;
  logic drive_en;
  logic invert;
  logic edge_seen;
  modport core (output fire, output drive_en, output invert, input edge_seen);
  modport pin  (input fire, input drive_en, input invert, output edge_seen);
endinterface

// ==== cts_pkg.sv ====
// Purpose: Constants for the cascade trigger block: register map, field positions, timing.
// Assumes: 250 MHz pclk, APB register access with 32-bit data.
// Notes: Two field layouts: packed objects and an index/subindex window.
// Notes on behaviour
// - Cascading works only with the enable field set to 1, master included.
// - Role field 1 makes this curtain the master that drives the cascade trigger.
// - Role field 0 makes it a slave that only scans after an outside trigger.
// - The master repeats its trigger every programmed cycle time in milliseconds.
// - A slave starts its scan a programmed number of microseconds after the trigger.
// - On the master, output function value 3 makes the pin drive the trigger.
// - On a slave, input function value 1 makes the pin receive the trigger.
// - Switching behaviour 0 is light switching, used on every curtain of the cascade.
// - Direction field 1 sets the pin as an input, as slaves need.
// - Packed cascade object: enable at bit 56, role at bit 48, time field at bit 32.
// - Packed pin object: direction at 24, switching at 16, input function at 8.
package cts_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 4;
  localparam int US_NS             = 1000;
  localparam int MS_NS             = 1000000;
  localparam int US_CYCLES         = US_NS / CLK_PERIOD_NS;
  localparam int MS_CYCLES         = MS_NS / CLK_PERIOD_NS;
  localparam int TRIG_PULSE_US     = 10;
  localparam int TRIG_PULSE_CYCLES = (TRIG_PULSE_US * US_NS) / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CASC_LO_OFS = 8'h00;
  localparam logic [7:0] CASC_HI_OFS = 8'h04;
  localparam logic [7:0] PIN_OFS     = 8'h08;
  localparam logic [7:0] STAT_OFS    = 8'h0c;
  localparam logic [7:0] OD_SEL_OFS  = 8'h10;
  localparam logic [7:0] OD_DATA_OFS = 8'h14;
  // ----------------------------------------------------------------
  // Packed object fields (bit offsets within 64-bit cascade object and within pin object)
  // ----------------------------------------------------------------
  localparam int CASC_EN_BIT   = 56;
  localparam int CASC_ROLE_BIT = 48;
  localparam int CASC_TIME_LSB = 32;
  localparam int PIN_DIR_BIT   = 24;
  localparam int PIN_SW_BIT    = 16;
  localparam int PIN_INFN_LSB  = 8;
  localparam int PIN_OUTFN_LSB = 0;
  localparam int TIME_W        = 16;
  // ----------------------------------------------------------------
  // Field values and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OUTFN_TRIG = 8'h03;
  localparam logic [7:0] INFN_TRIG  = 8'h01;
  localparam logic       ROLE_MASTER = 1'b1;
  localparam logic       DIR_INPUT   = 1'b1;
  localparam logic       SW_LIGHT    = 1'b0;
  localparam logic [15:0] TIME_RST   = 16'h0000;
  // ----------------------------------------------------------------
  // Subindex window
  // ----------------------------------------------------------------
  localparam int         OD_OBJ_BIT   = 8;
  localparam logic [3:0] SUB_EN       = 4'h1;
  localparam logic [3:0] SUB_ROLE     = 4'h2;
  localparam logic [3:0] SUB_DELAY    = 4'h3;
  localparam logic [3:0] SUB_CYCLE    = 4'h5;
  localparam logic [3:0] SUB_OUTFN    = 4'h1;
  localparam logic [3:0] SUB_INFN     = 4'h2;
  localparam logic [3:0] SUB_SW       = 4'h3;
  localparam logic [3:0] SUB_DIR      = 4'h4;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_MCYCLE = 2'b01,
    ST_SDELAY = 2'b10
  } cts_state_t;
endpackage

// ==== cts_tick.sv ====
// Purpose: Divides pclk into a one-cycle tick every DIV cycles.
// Assumes: DIV of at least 2.
// Notes: clr restarts the division so the first tick comes DIV cycles later.
`timescale 1ns/1ns
module cts_tick #(
  parameter int unsigned DIV = 250
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Control
  input  wire logic clr,
  output logic      tick
);
  localparam int W = $clog2(DIV + 1);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else if (clr) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else begin
      tick    <= (cnt_reg == LAST);
      cnt_reg <= (cnt_reg == LAST) ? '0 : cnt_reg + W'(1);
    end
  end
endmodule

// ==== cts_top.sv ====
// Purpose: Cascade trigger controller with APB registers.
// Assumes: APB3 slave, one wait state per access; pin input synchronous.
// Notes: Master counts milliseconds, slave counts microseconds.
`timescale 1ns/1ns
module cts_top
  import cts_pkg::*;
#(
  parameter int unsigned MS_DIV = MS_CYCLES,
  parameter int unsigned US_DIV = US_CYCLES
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Trigger pin
  input  wire logic        trig_pin_i,
  output logic             trig_pin_o,
  output logic             trig_pin_oe,
  // Scan control
  output logic             scan_start_o
);
  // ----------------------------------------------------------------
  // Configuration state
  // ----------------------------------------------------------------
  logic              casc_en_reg;
  logic              role_reg;
  logic [TIME_W-1:0] cycle_ms_reg;
  logic [TIME_W-1:0] delay_us_reg;
  logic              pin_dir_reg;
  logic              pin_sw_reg;
  logic [7:0]        in_fn_reg;
  logic [7:0]        out_fn_reg;
  logic              od_obj_reg;
  logic [3:0]        od_sub_reg;

  cts_state_t        state_reg;
  logic [TIME_W-1:0] cnt_reg;
  logic [15:0]       scan_cnt_reg;
  logic              fire_reg;
  logic              drive_reg;
  logic              inv_reg;

  logic master_ok;
  logic slave_ok;
  logic ms_tick;
  logic us_tick;
  logic ms_clr;
  logic us_clr;
  logic acc;
  logic wr_en;
  logic rd_hit;
  logic od_hit;
  logic [31:0] rd_data;
  logic [31:0] od_rd;
  logic [31:0] hi_word;
  logic [31:0] pin_word;
  logic [31:0] stat_word;

  cts_pin_if pif ();

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  assign master_ok = casc_en_reg && (role_reg == ROLE_MASTER)
                     && (pin_dir_reg != DIR_INPUT)
                     && (out_fn_reg == OUTFN_TRIG);
  assign slave_ok  = casc_en_reg && (role_reg != ROLE_MASTER)
                     && (pin_dir_reg == DIR_INPUT)
                     && (in_fn_reg == INFN_TRIG);

  // ----------------------------------------------------------------
  // Time bases
  // ----------------------------------------------------------------
  cts_tick #(.DIV(MS_DIV)) u_ms_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (ms_clr),
    .tick    (ms_tick)
  );

  cts_tick #(.DIV(US_DIV)) u_us_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (us_clr),
    .tick    (us_tick)
  );

  assign ms_clr = (state_reg != ST_MCYCLE);
  assign us_clr = (state_reg != ST_SDELAY);

  // ----------------------------------------------------------------
  // Pin stage
  // ----------------------------------------------------------------
  assign pif.fire     = fire_reg;
  assign pif.drive_en = drive_reg;
  assign pif.invert   = inv_reg;

  cts_pin u_pin (
    .pclk        (pclk),
    .presetn     (presetn),
    .pif         (pif.pin),
    .trig_pin_i  (trig_pin_i),
    .trig_pin_o  (trig_pin_o),
    .trig_pin_oe (trig_pin_oe)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_reg <= 1'b0;
      inv_reg   <= 1'b0;
    end else begin
      drive_reg <= master_ok;
      inv_reg   <= (pin_sw_reg != SW_LIGHT);
    end
  end

  // ----------------------------------------------------------------
  // Trigger sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= ST_IDLE;
      cnt_reg      <= TIME_RST;
      fire_reg     <= 1'b0;
      scan_start_o <= 1'b0;
    end else begin
      fire_reg     <= 1'b0;
      scan_start_o <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (master_ok && cycle_ms_reg != '0) begin
            state_reg    <= ST_MCYCLE;
            cnt_reg      <= cycle_ms_reg;
            fire_reg     <= 1'b1;
            scan_start_o <= 1'b1;
          end else if (slave_ok && pif.edge_seen) begin
            if (delay_us_reg == '0) begin
              scan_start_o <= 1'b1;
            end else begin
              state_reg <= ST_SDELAY;
              cnt_reg   <= delay_us_reg;
            end
          end
        end
        ST_MCYCLE: begin
          if (!master_ok || cycle_ms_reg == '0) begin
            state_reg <= ST_IDLE;
          end else if (ms_tick) begin
            if (cnt_reg <= TIME_W'(1)) begin
              cnt_reg      <= cycle_ms_reg;
              fire_reg     <= 1'b1;
              scan_start_o <= 1'b1;
            end else begin
              cnt_reg <= cnt_reg - TIME_W'(1);
            end
          end
        end
        ST_SDELAY: begin
          // Edges during the delay are ignored
          if (!slave_ok) begin
            state_reg <= ST_IDLE;
          end else if (us_tick) begin
            if (cnt_reg <= TIME_W'(1)) begin
              state_reg    <= ST_IDLE;
              scan_start_o <= 1'b1;
            end else begin
              cnt_reg <= cnt_reg - TIME_W'(1);
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_cnt_reg <= 16'h0000;
    end else if (scan_start_o) begin
      scan_cnt_reg <= scan_cnt_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Register read views
  // ----------------------------------------------------------------
  always_comb begin
    hi_word = 32'h0000_0000;
    hi_word[CASC_EN_BIT-32]   = casc_en_reg;
    hi_word[CASC_ROLE_BIT-32] = role_reg;
    hi_word[CASC_TIME_LSB-32 +: TIME_W] = role_reg ? cycle_ms_reg : delay_us_reg;
    pin_word = 32'h0000_0000;
    pin_word[PIN_DIR_BIT]             = pin_dir_reg;
    pin_word[PIN_SW_BIT]              = pin_sw_reg;
    pin_word[PIN_INFN_LSB +: 8]       = in_fn_reg;
    pin_word[PIN_OUTFN_LSB +: 8]      = out_fn_reg;
    stat_word = {scan_cnt_reg, 10'h000, state_reg, trig_pin_i,
                 casc_en_reg && !master_ok && !slave_ok, slave_ok, master_ok};
  end

  // Subindex window
  always_comb begin
    od_rd  = 32'h0000_0000;
    od_hit = 1'b1;
    if (!od_obj_reg) begin
      unique case (od_sub_reg)
        SUB_EN:    od_rd[0] = casc_en_reg;
        SUB_ROLE:  od_rd[0] = role_reg;
        SUB_DELAY: od_rd[TIME_W-1:0] = delay_us_reg;
        SUB_CYCLE: od_rd[TIME_W-1:0] = cycle_ms_reg;
        default:   od_hit = 1'b0;
      endcase
    end else begin
      unique case (od_sub_reg)
        SUB_OUTFN: od_rd[7:0] = out_fn_reg;
        SUB_INFN:  od_rd[7:0] = in_fn_reg;
        SUB_SW:    od_rd[0] = pin_sw_reg;
        SUB_DIR:   od_rd[0] = pin_dir_reg;
        default:   od_hit = 1'b0;
      endcase
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case (paddr)
      CASC_LO_OFS: rd_data = 32'h0000_0000;
      CASC_HI_OFS: rd_data = hi_word;
      PIN_OFS:     rd_data = pin_word;
      STAT_OFS:    rd_data = stat_word;
      OD_SEL_OFS:  rd_data = {23'h000000, od_obj_reg, 4'h0, od_sub_reg};
      OD_DATA_OFS: begin
        rd_data = od_rd;
        rd_hit  = od_hit;
      end
      default:     rd_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // APB handshake: one wait state
  // ----------------------------------------------------------------
  assign acc   = psel && penable && !pready;
  assign wr_en = psel && penable && pready && pwrite && !pslverr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc;
      pslverr <= acc && (!rd_hit || (pwrite && paddr == STAT_OFS));
      prdata  <= (acc && !pwrite && rd_hit) ? rd_data : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      casc_en_reg  <= 1'b0;
      role_reg     <= 1'b0;
      cycle_ms_reg <= TIME_RST;
      delay_us_reg <= TIME_RST;
    end else if (wr_en && paddr == CASC_HI_OFS) begin
      casc_en_reg <= pwdata[CASC_EN_BIT-32];
      role_reg    <= pwdata[CASC_ROLE_BIT-32];
      if (pwdata[CASC_ROLE_BIT-32]) begin
        cycle_ms_reg <= pwdata[CASC_TIME_LSB-32 +: TIME_W];
      end else begin
        delay_us_reg <= pwdata[CASC_TIME_LSB-32 +: TIME_W];
      end
    end else if (wr_en && paddr == OD_DATA_OFS && !od_obj_reg) begin
      unique case (od_sub_reg)
        SUB_EN:    casc_en_reg  <= pwdata[0];
        SUB_ROLE:  role_reg     <= pwdata[0];
        SUB_DELAY: delay_us_reg <= pwdata[TIME_W-1:0];
        SUB_CYCLE: cycle_ms_reg <= pwdata[TIME_W-1:0];
        default:   casc_en_reg  <= casc_en_reg;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_dir_reg <= 1'b0;
      pin_sw_reg  <= SW_LIGHT;
      in_fn_reg   <= 8'h00;
      out_fn_reg  <= 8'h00;
    end else if (wr_en && paddr == PIN_OFS) begin
      pin_dir_reg <= pwdata[PIN_DIR_BIT];
      pin_sw_reg  <= pwdata[PIN_SW_BIT];
      in_fn_reg   <= pwdata[PIN_INFN_LSB +: 8];
      out_fn_reg  <= pwdata[PIN_OUTFN_LSB +: 8];
    end else if (wr_en && paddr == OD_DATA_OFS && od_obj_reg) begin
      unique case (od_sub_reg)
        SUB_OUTFN: out_fn_reg  <= pwdata[7:0];
        SUB_INFN:  in_fn_reg   <= pwdata[7:0];
        SUB_SW:    pin_sw_reg  <= pwdata[0];
        SUB_DIR:   pin_dir_reg <= pwdata[0];
        default:   pin_dir_reg <= pin_dir_reg;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      od_obj_reg <= 1'b0;
      od_sub_reg <= 4'h0;
    end else if (wr_en && paddr == OD_SEL_OFS) begin
      od_obj_reg <= pwdata[OD_OBJ_BIT];
      od_sub_reg <= pwdata[3:0];
    end
  end
endmodule
